// ---- core/flag_clear_cfg.svh ----
// constants for the flag clear unit: opcodes, flag positions, counts
`ifndef FLAG_CLEAR_CFG_SVH
`define FLAG_CLEAR_CFG_SVH

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define OP_CARRY_CLEAR 8'hf8
`define OP_DIR_CLEAR 8'hfc
`define OP_INT_DISABLE 8'hfa
`define OP_INT_ENABLE 8'hfb
`define OP_DIR_SET 8'hfd
`define OP_CARRY_SET 8'hf9
`define OP_CARRY_CMPL 8'hf5
`define OP_INT_RETURN 8'hcf
`define OP_SOFT_INT 8'hcd
`define OP_RCL_BYTE 8'hd0
`define OP_STRING_STEP 8'ha4

// ----------------------------------------------------------------------
// status word bit positions and reset value
// ----------------------------------------------------------------------
`define FLAG_CARRY_BIT 0
`define FLAG_INT_BIT 9
`define FLAG_DIR_BIT 10
`define FLAGS_RESET 16'h0002

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FLAG_OP_CYCLES 2
`define OTHER_OP_CYCLES 2

// ----------------------------------------------------------------------
// axi4-lite register map (byte addresses)
// ----------------------------------------------------------------------
`define REG_CMD 8'h00
`define REG_STATUS 8'h04
`define REG_FLAGS 8'h08
`define REG_SRC_IDX 8'h0c
`define REG_DST_IDX 8'h10
`define REG_OPERAND 8'h14
`define REG_INT_REQ 8'h18
`define REG_VECTOR 8'h1c
`define REG_RESTORE 8'h20

`endif

// ---- core/flag_clear_pkg.sv ----
// types shared by the flag clear unit files
package flag_clear_pkg;
  typedef enum logic [1:0] {
    ex_idle,
    ex_busy,
    ex_done
  } exec_state_t;

  typedef enum logic [1:0] {
    vec_none,
    vec_maskable,
    vec_soft,
    vec_nmi
  } vector_kind_t;
endpackage

// ---- core/op_decode_if.sv ----
// interface carrying a decoded instruction between modules
`timescale 1ns/1ps
interface op_decode_if;
  logic [7:0] opcode;
  logic carry_clr;
  logic carry_set;
  logic carry_cmpl;
  logic dir_clr;
  logic dir_set;
  logic int_dis;
  logic int_en;
  logic int_ret;
  logic soft_int;
  logic rot_carry;
  logic string_op;
  logic known;
  modport src (input opcode, output carry_clr, carry_set, carry_cmpl,
    dir_clr, dir_set, int_dis, int_en, int_ret, soft_int, rot_carry,
    string_op, known);
  modport dst (output opcode, input carry_clr, carry_set, carry_cmpl,
    dir_clr, dir_set, int_dis, int_en, int_ret, soft_int, rot_carry,
    string_op, known);
endinterface

// ---- core/op_decoder.sv ----
// single-byte opcode decoder
`timescale 1ns/1ps
`include "flag_clear_cfg.svh"
module op_decoder
  import flag_clear_pkg::*;
(
  op_decode_if.src dec
);
  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  // one strobe per recognised opcode, except string_op, which a4 and a5 share
  always_comb begin
    // [RQ13] carry clear decode
    dec.carry_clr = (dec.opcode == `OP_CARRY_CLEAR);
    dec.carry_set = (dec.opcode == `OP_CARRY_SET);
    dec.carry_cmpl = (dec.opcode == `OP_CARRY_CMPL);
    // [RQ3] direction clear decode
    dec.dir_clr = (dec.opcode == `OP_DIR_CLEAR);
    dec.dir_set = (dec.opcode == `OP_DIR_SET);
    // [RQ7] interrupt disable decode
    dec.int_dis = (dec.opcode == `OP_INT_DISABLE);
    dec.int_en = (dec.opcode == `OP_INT_ENABLE);
    dec.int_ret = (dec.opcode == `OP_INT_RETURN);
    dec.soft_int = (dec.opcode == `OP_SOFT_INT);
    dec.rot_carry = (dec.opcode == `OP_RCL_BYTE);
    dec.string_op = (dec.opcode[7:1] == 7'(`OP_STRING_STEP >> 1));
    dec.known = dec.carry_clr | dec.carry_set | dec.carry_cmpl |
      dec.dir_clr | dec.dir_set | dec.int_dis | dec.int_en |
      dec.int_ret | dec.soft_int | dec.rot_carry | dec.string_op;
  end
endmodule // op_decoder

// ---- core/axil_slave.sv ----
// axi4-lite register slave front end, one write and one read at a time
`timescale 1ns/1ps
`include "flag_clear_cfg.svh"
module axil_slave
  import flag_clear_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bus_state_t;

  bus_state_t st_r;
  bus_state_t st_nxt;

  // ----------------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------------
  assign s_axil_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axil_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axil_arready = !st_r.rvalid;
  assign s_axil_bvalid = st_r.bvalid;
  assign s_axil_bresp = st_r.bresp;
  assign s_axil_rvalid = st_r.rvalid;
  assign s_axil_rdata = st_r.rdata;
  assign s_axil_rresp = st_r.rresp;
  assign wr_addr = st_r.awaddr;
  assign wr_data = st_r.wdata;
  assign wr_strb = st_r.wstrb;
  assign wr_en = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign rd_addr = s_axil_araddr;

  // next bus state
  always_comb begin
    st_nxt = st_r;
    if (s_axil_awvalid && s_axil_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axil_wdata;
      st_nxt.wstrb = s_axil_wstrb;
    end
    if (wr_en) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_err ? 2'h2 : 2'h0; // slverr on unmapped
    end
    if (st_r.bvalid && s_axil_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axil_arvalid && s_axil_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_data;
      st_nxt.rresp = rd_err ? 2'h2 : 2'h0;
    end else if (st_r.rvalid && s_axil_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  // register the bus state
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // axil_slave

// ---- core/flag_clear_unit.sv ----
// flag clear instruction unit: flags, string stepping, interrupt gating
//
// Overview of operation
// [RQ1] carry-clear forces carry to zero so rotates shift in zero
// [RQ2] carry holds through instructions not defined to touch it
// [RQ3] opcode fc clears direction in two cycles on both bus widths
// [RQ4] direction zero makes string ops increment their index registers
// [RQ5] every string op advances its indexes, repeated or not
// [RQ6] step one for bytes, two for words, sign from direction
// [RQ7] opcode fa clears interrupt-enable in two cycles
// [RQ8] no maskable request accepted while interrupt-enable is clear
// [RQ9] software, trap and nonmaskable interrupts ignore interrupt-enable; the unit has only software and nonmaskable sources, no trap
// [RQ10] software interrupt vectors even with interrupt-enable clear
// [RQ11] interrupt return restores the whole flags word from the stack copy
// [RQ12] maskable requests wait one instruction after interrupt-enable
// [RQ13] opcode f8 clears carry in two cycles
// [RQ14] each clear touches only its own flag
`timescale 1ns/1ps
`include "flag_clear_cfg.svh"
module flag_clear_unit
  import flag_clear_pkg::*;
#(
  parameter int unsigned OP_CYCLES = `FLAG_OP_CYCLES,
  parameter int unsigned IDX_W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic maskable_req,
  input wire logic nmi_req,
  output logic [15:0] flags_out,
  output logic vector_taken,
  output logic [1:0] vector_kind
);
  localparam int unsigned CNT_W = $clog2(OP_CYCLES + 1);

  typedef struct packed {
    exec_state_t state;
    logic [7:0] opcode;
    logic word_op;
    logic [CNT_W-1:0] cnt;
    logic [15:0] flags;
    logic [IDX_W-1:0] src_idx;
    logic [IDX_W-1:0] dst_idx;
    logic [7:0] operand;
    logic [15:0] restore;
    logic int_shadow;
    logic nmi_pend;
    logic taken;
    vector_kind_t kind;
    logic [31:0] retired;
  } core_state_t;

  core_state_t st_r;
  core_state_t st_nxt;

  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic [IDX_W-1:0] step;
  logic op_done;
  logic int_window;

  op_decode_if dec ();

  // ----------------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------------
  assign dec.opcode = st_r.opcode;

  op_decoder u_dec (
    .dec (dec)
  );

  axil_slave u_bus (
    .clk (clk),
    .srst (srst),
    .s_axil_awaddr (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata (s_axil_wdata),
    .s_axil_wstrb (s_axil_wstrb),
    .s_axil_wvalid (s_axil_wvalid),
    .s_axil_wready (s_axil_wready),
    .s_axil_bresp (s_axil_bresp),
    .s_axil_bvalid (s_axil_bvalid),
    .s_axil_bready (s_axil_bready),
    .s_axil_araddr (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata (s_axil_rdata),
    .s_axil_rresp (s_axil_rresp),
    .s_axil_rvalid (s_axil_rvalid),
    .s_axil_rready (s_axil_rready),
    .wr_en (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err (wr_err),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_err (rd_err)
  );

  // ----------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------
  // unmapped addresses answer slverr
  always_comb begin
    unique case (wr_addr)
      `REG_CMD, `REG_FLAGS, `REG_SRC_IDX, `REG_DST_IDX, `REG_OPERAND,
      `REG_RESTORE: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
    rd_err = 1'b0;
    unique case (rd_addr)
      `REG_CMD: rd_data = {23'h0, st_r.word_op, st_r.opcode};
      `REG_STATUS: rd_data = {28'h0, st_r.int_shadow, st_r.kind,
        st_r.state != ex_idle};
      `REG_FLAGS: rd_data = {16'h0, st_r.flags};
      `REG_SRC_IDX: rd_data = 32'(st_r.src_idx);
      `REG_DST_IDX: rd_data = 32'(st_r.dst_idx);
      `REG_OPERAND: rd_data = {24'h0, st_r.operand};
      `REG_VECTOR: rd_data = st_r.retired;
      `REG_RESTORE: rd_data = {16'h0, st_r.restore};
      default: begin
        rd_data = 32'h0;
        rd_err = 1'b1;
      end
    endcase
  end

  // [RQ6] step size and sign
  assign step = st_r.word_op ? IDX_W'(2) : IDX_W'(1);
  assign op_done = (st_r.state == ex_busy) &&
    (st_r.cnt == CNT_W'(OP_CYCLES - 1));
  // [RQ8] maskable gated by enable and shadow
  assign int_window = st_r.flags[`FLAG_INT_BIT] && !st_r.int_shadow;

  // ----------------------------------------------------------------------
  // execution
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.taken = 1'b0;
    // [RQ9] nonmaskable latched regardless
    if (nmi_req) begin
      st_nxt.nmi_pend = 1'b1;
    end
    unique case (st_r.state)
      ex_idle: begin
        if (wr_en && !wr_err && wr_addr == `REG_CMD && wr_strb[0]) begin
          st_nxt.opcode = wr_data[7:0];
          st_nxt.word_op = wr_data[8];
          st_nxt.cnt = '0;
          st_nxt.state = ex_busy;
        end else if (wr_en && !wr_err) begin
          unique case (wr_addr)
            `REG_FLAGS: st_nxt.flags = wr_data[15:0];
            `REG_SRC_IDX: st_nxt.src_idx = wr_data[IDX_W-1:0];
            `REG_DST_IDX: st_nxt.dst_idx = wr_data[IDX_W-1:0];
            `REG_OPERAND: st_nxt.operand = wr_data[7:0];
            `REG_RESTORE: st_nxt.restore = wr_data[15:0];
            default: st_nxt.opcode = st_r.opcode;
          endcase
        end
      end
      ex_busy: begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
        if (op_done) begin
          st_nxt.state = ex_done;
          st_nxt.retired = st_r.retired + 32'h1;
          // [RQ12] shadow lasts one instruction
          st_nxt.int_shadow = dec.int_en;
          // [RQ14] only the target flag moves; [RQ2] carry otherwise held
          if (dec.carry_clr) begin
            // [RQ1] carry forced to zero
            st_nxt.flags[`FLAG_CARRY_BIT] = 1'b0;
          end
          if (dec.carry_set) begin
            st_nxt.flags[`FLAG_CARRY_BIT] = 1'b1;
          end
          if (dec.carry_cmpl) begin
            st_nxt.flags[`FLAG_CARRY_BIT] = !st_r.flags[`FLAG_CARRY_BIT];
          end
          if (dec.dir_clr) begin
            // [RQ4] direction cleared to zero
            st_nxt.flags[`FLAG_DIR_BIT] = 1'b0;
          end
          if (dec.dir_set) begin
            st_nxt.flags[`FLAG_DIR_BIT] = 1'b1;
          end
          if (dec.int_dis) begin
            // [RQ7] interrupt enable cleared
            st_nxt.flags[`FLAG_INT_BIT] = 1'b0;
          end
          if (dec.int_en) begin
            st_nxt.flags[`FLAG_INT_BIT] = 1'b1;
          end
          if (dec.int_ret) begin
            // [RQ11] whole flags word reloaded
            st_nxt.flags = st_r.restore;
          end
          if (dec.rot_carry) begin
            // rotate left through carry, carry enters bit 0
            st_nxt.operand = {st_r.operand[6:0],
              st_r.flags[`FLAG_CARRY_BIT]};
            st_nxt.flags[`FLAG_CARRY_BIT] = st_r.operand[7];
          end
          if (dec.string_op) begin
            // [RQ5] advance both indexes every element
            if (st_r.flags[`FLAG_DIR_BIT]) begin
              st_nxt.src_idx = st_r.src_idx - step;
              st_nxt.dst_idx = st_r.dst_idx - step;
            end else begin
              st_nxt.src_idx = st_r.src_idx + step;
              st_nxt.dst_idx = st_r.dst_idx + step;
            end
          end
        end
      end
      ex_done: begin
        st_nxt.state = ex_idle;
        // [RQ10] software interrupt ignores enable
        if (dec.soft_int) begin
          st_nxt.taken = 1'b1;
          st_nxt.kind = vec_soft;
        end else if (st_r.nmi_pend || nmi_req) begin
          st_nxt.taken = 1'b1;
          st_nxt.kind = vec_nmi;
          st_nxt.nmi_pend = 1'b0;
        end else if (maskable_req && int_window) begin
          st_nxt.taken = 1'b1;
          st_nxt.kind = vec_maskable;
        end else begin
          st_nxt.kind = vec_none;
        end
        // stack copy only when a vector is really taken
        if (dec.soft_int || st_r.nmi_pend || nmi_req ||
            (maskable_req && int_window)) begin
          st_nxt.restore = st_r.flags; // stacked copy on entry
        end
      end
      default: st_nxt.state = ex_idle;
    endcase
  end

  // register the core state
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.flags <= `FLAGS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs from flip-flops
  assign flags_out = st_r.flags;
  assign vector_taken = st_r.taken;
  assign vector_kind = st_r.kind;
endmodule // flag_clear_unit

// ---- dv/flag_clear_unit_assertions.sv ----
// port-level checks for the flag clear unit
`timescale 1ns/1ps
`include "flag_clear_cfg.svh"
module flag_clear_unit_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic [1:0] s_axil_bresp,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0] s_axil_rresp,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic [15:0] flags_out,
  input wire logic vector_taken,
  input wire logic [1:0] vector_kind
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  a_wr_answer_soon: assert property (s_axil_awvalid && s_axil_awready &&
    s_axil_wvalid && s_axil_wready |-> ##[1:2] s_axil_bvalid)
    else $error("write response missing");
  a_bresp_holds: assert property (s_axil_bvalid && !s_axil_bready |=>
    s_axil_bvalid && $stable(s_axil_bresp)) else $error("bresp dropped");
  a_busy_no_ready: assert property (s_axil_bvalid |->
    !s_axil_awready && !s_axil_wready) else $error("ready during resp");
  a_rd_answer_next: assert property (s_axil_arvalid && s_axil_arready |=>
    s_axil_rvalid) else $error("read answer late");
  a_rdata_holds: assert property (s_axil_rvalid && !s_axil_rready |=>
    s_axil_rvalid && $stable(s_axil_rdata) && $stable(s_axil_rresp))
    else $error("rdata dropped");
  a_unmapped_read: assert property (s_axil_arvalid && s_axil_arready &&
    s_axil_araddr == 8'h18 |=> s_axil_rresp == 2'b10 &&
    s_axil_rdata == 32'h0) else $error("unmapped read accepted");
  // ----------------------------------------------------------------
  // interrupt acceptance and reset
  // ----------------------------------------------------------------
  a_vec_one_pulse: assert property (vector_taken |=> !vector_taken)
    else $error("vector pulse too long");
  a_mask_gate: assert property (
    vector_taken && vector_kind == 2'h1 |-> $past(flags_out[`FLAG_INT_BIT]))
    else $error("maskable taken while disabled");
  a_vec_kind_set: assert property (
    vector_taken |-> vector_kind != 2'h0) else $error("vector kind none");
  a_reset_flags: assert property ($fell(srst) |->
    flags_out == `FLAGS_RESET && !vector_taken) else $error("reset flags");
  c_maskable: cover property (vector_taken && vector_kind == 2'h1);
  c_soft: cover property (vector_taken && vector_kind == 2'h2);
  c_nmi: cover property (vector_taken && vector_kind == 2'h3);
  c_bstall: cover property (s_axil_bvalid && !s_axil_bready);
endmodule // flag_clear_unit_chk

bind flag_clear_unit flag_clear_unit_chk chk (.clk, .srst, .s_axil_awvalid,
  .s_axil_awready, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
  .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid,
  .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid,
  .s_axil_rready, .flags_out, .vector_taken, .vector_kind);

// ---- dv/flag_clear_unit_tb.sv ----
// self-checking bench for the flag clear unit
`timescale 1ns/1ps
`include "flag_clear_cfg.svh"
module flag_clear_unit_tb;
  logic clk = 0, srst = 1, s_axil_awvalid = 0, s_axil_wvalid = 0;
  logic s_axil_bready = 0, s_axil_arvalid = 0, s_axil_rready = 0;
  logic maskable_req = 0, nmi_req = 0, s_axil_awready, s_axil_wready;
  logic s_axil_bvalid, s_axil_arready, s_axil_rvalid, vector_taken;
  logic [7:0] s_axil_awaddr = 0, s_axil_araddr = 0;
  logic [31:0] s_axil_wdata = 0, s_axil_rdata;
  logic [3:0] s_axil_wstrb = 0;
  logic [1:0] s_axil_bresp, s_axil_rresp, vector_kind, last_kind;
  logic [15:0] flags_out, seed = 16'h0019;
  int n_errors = 0, tests_run = 0, n_vec = 0, cyc = 0;

  flag_clear_unit DUT (.clk, .srst, .s_axil_awaddr, .s_axil_awvalid,
    .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid,
    .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
    .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
    .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .maskable_req,
    .nmi_req, .flags_out, .vector_taken, .vector_kind);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial forever #5 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // expected flags after one clear opcode
  function automatic logic [15:0] cleared(input logic [15:0] f,
      input logic [7:0] op);
    if (op == `OP_CARRY_CLEAR) f[`FLAG_CARRY_BIT] = 1'b0;
    else if (op == `OP_DIR_CLEAR) f[`FLAG_DIR_BIT] = 1'b0;
    else f[`FLAG_INT_BIT] = 1'b0;
    return f;
  endfunction
  function automatic logic [31:0] stepped(input logic [15:0] x,
      input logic dn, input logic w);
    return {16'h0, dn ? x - (w ? 16'h2 : 16'h1) : x + (w ? 16'h2 : 16'h1)};
  endfunction
  task automatic chk_val(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_code(input logic [1:0] e, input logic [1:0] g);
    chk_val({30'h0, e}, {30'h0, g});
  endtask
  task automatic test_done;
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // vector monitor and hang guard
  always @(posedge clk) begin
    cyc++;
    if (vector_taken === 1'b1) begin
      n_vec++;
      last_kind = vector_kind;
    end
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  // write: aw and w together, bready raised once bvalid stands
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_wstrb <= 4'hf;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axil_awready === 1'b1) s_axil_awvalid <= 1'b0;
      if (s_axil_wready === 1'b1) s_axil_wvalid <= 1'b0;
    end while (s_axil_bvalid !== 1'b1);
    s_axil_bready <= 1'b1;
    @(posedge clk);
    r = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axil_arready === 1'b1) s_axil_arvalid <= 1'b0;
    end while (s_axil_rvalid !== 1'b1);
    s_axil_rready <= 1'b1;
    @(posedge clk);
    d = s_axil_rdata;
    r = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk_code(2'b00, r);
  endtask
  // issue one instruction and wait for the unit to go idle
  task automatic exec(input logic [8:0] c);
    logic [31:0] s;
    logic [1:0] r;
    wr(`REG_CMD, {23'h0, c});
    do axr(`REG_STATUS, s, r); while (s[0] !== 1'b0);
    repeat (2) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [15:0] f;
    logic [1:0] r;
    logic [7:0] op;
    int v;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    axr(`REG_FLAGS, d, r);
    chk_val({16'h0, `FLAGS_RESET}, d);
    // random flags, each clear hits one bit only
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      f = (seed & 16'h0ed5) | 16'h0603;
      op = (i % 3 == 0) ? `OP_CARRY_CLEAR :
        (i % 3 == 1) ? `OP_DIR_CLEAR : `OP_INT_DISABLE;
      wr(`REG_FLAGS, {16'h0, f});
      wr(`REG_DST_IDX, {16'h0, seed});
      exec({1'b0, op});
      axr(`REG_FLAGS, d, r);
      chk_val({16'h0, cleared(f, op)}, d);
      axr(`REG_DST_IDX, d, r);
      chk_val({16'h0, seed}, d);
    end
    $display("clear opcodes done");
    // zero rotated in, carry then kept
    wr(`REG_FLAGS, 32'h0003);
    wr(`REG_OPERAND, 32'h81);
    exec({1'b0, `OP_CARRY_CLEAR});
    exec({1'b0, `OP_RCL_BYTE});
    axr(`REG_OPERAND, d, r);
    chk_val(32'h02, {24'h0, d[7:0]});
    exec({1'b0, `OP_DIR_SET});
    axr(`REG_FLAGS, d, r);
    chk_val(32'h1, {31'h0, d[`FLAG_CARRY_BIT]});
    $display("rotate done");
    // step size and sign for every direction and size
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      exec(i[1] ? {1'b0, `OP_DIR_SET} : {1'b0, `OP_DIR_CLEAR});
      wr(`REG_SRC_IDX, {16'h0, seed});
      wr(`REG_DST_IDX, {16'h0, ~seed});
      exec({i[0], `OP_STRING_STEP});
      axr(`REG_SRC_IDX, d, r);
      chk_val(stepped(seed, i[1], i[0]), d);
      axr(`REG_DST_IDX, d, r);
      chk_val(stepped(~seed, i[1], i[0]), d);
    end
    $display("string steps done");
    // masked after disable, one instruction late after enable
    wr(`REG_FLAGS, 32'h0202);
    maskable_req <= 1'b1;
    v = n_vec;
    exec({1'b0, `OP_INT_DISABLE});
    chk_val(v, n_vec);
    exec({1'b0, `OP_INT_ENABLE});
    chk_val(v, n_vec);
    exec({1'b0, `OP_CARRY_CLEAR});
    maskable_req <= 1'b0;
    chk_val(v + 1, n_vec);
    chk_code(2'h1, last_kind);
    // software vector with enable clear, then return
    seed = lfsr(seed);
    f = (seed & 16'h0cd5) | 16'h0002;
    wr(`REG_FLAGS, {16'h0, f});
    exec({1'b0, `OP_SOFT_INT});
    chk_val(v + 2, n_vec);
    chk_code(2'h2, last_kind);
    exec({1'b0, `OP_INT_ENABLE});
    exec({1'b0, `OP_INT_RETURN});
    axr(`REG_FLAGS, d, r);
    chk_val({16'h0, f}, d);
    nmi_req <= 1'b1;
    @(posedge clk);
    nmi_req <= 1'b0;
    exec({1'b0, `OP_CARRY_CLEAR});
    chk_val(v + 3, n_vec);
    chk_code(2'h3, last_kind);
    $display("interrupts done");
    axw(8'h18, {16'h0, seed}, r);
    chk_code(2'b10, r);
    axr(8'h18, d, r);
    chk_code(2'b10, r);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    axr(`REG_FLAGS, d, r);
    chk_val({16'h0, `FLAGS_RESET}, d);
    $display("bus and reset done");
    test_done();
  end
endmodule // flag_clear_unit_tb
